// file: verilog/kscan_port_status_regs.sv
// What this block does
// RULE_01: bit 7 set makes shared pin segment driver
// RULE_02: modes 000/001 give open-drain low/high output
// RULE_03: modes 010/011 give active-low/high interrupt
// RULE_04: bits 4 and 3 pick port roles
// RULE_05: read returns setup, port levels, interrupt flag
// RULE_06: two keyscan ports give eight keys, one four
// RULE_07: latched bit sets once key debounced since read
// RULE_08: latched read returns then clears; events OR in
// RULE_09: latched read also clears interrupt flag and pin
// RULE_10: held key reported only once until released
// RULE_11: writes to latched register ignored
// RULE_12: live bits show keys pressed last scan
// RULE_13: live read has no side effect
// RULE_14: writes to live register ignored
// RULE_15: test register bit 0 selects test mode
// RULE_16: test mode lights all, keeps stored values
// RULE_17: test mode uses fixed 28/64 duty
// RULE_18: new key pressed both periods raises event
// RULE_19: scanned keys limited to twice enabled digits
// RULE_20: logic-input ports scan nothing, read zero
`timescale 1ns/10ps
module kscan_port_status_regs
  import kscan_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = KSCAN_SLAVE_ADDR,
  parameter int DIGIT_CYCLES = KSCAN_DIGIT_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda_in,
  input wire logic i_scan_port_a,
  input wire logic i_scan_port_b,
  input wire logic [1:0] i_scan_limit,
  input wire logic [5:0] i_intensity,
  input wire logic i_shutdown,
  input wire logic i_alert_seg_level,
  output logic o_sda_out,
  output logic o_sda_oe_b,
  output logic o_alert_out,
  output logic o_alert_oe_b,
  output logic [3:0] o_dig_drive_n,
  output logic o_force_all_on,
  output logic o_blank,
  output logic [5:0] o_duty_code
);
  typedef enum logic [5:0] {
    KSCAN_ST_IDLE = 6'h01,
    KSCAN_ST_ADDR = 6'h02,
    KSCAN_ST_SACK = 6'h04,
    KSCAN_ST_WBYTE = 6'h08,
    KSCAN_ST_RBYTE = 6'h10,
    KSCAN_ST_MACK = 6'h20
  } kscan_state_e;

  kscan_if sif ();

  kscan_scanner #(.DIGIT_CYCLES(DIGIT_CYCLES)) u_scanner (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .sif(sif)
  );

  // ----------------------------------------------------------------
  // pin synchronisers: link clock and ports are asynchronous
  // ----------------------------------------------------------------
  logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
  logic pa_m_r, pa_s_r, pb_m_r, pb_s_r;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
      pa_m_r <= 1'b1;
      pa_s_r <= 1'b1;
      pb_m_r <= 1'b1;
      pb_s_r <= 1'b1;
    end else begin
      scl_m_r <= i_scl;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= i_sda_in;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
      pa_m_r <= i_scan_port_a;
      pa_s_r <= pa_m_r;
      pb_m_r <= i_scan_port_b;
      pb_s_r <= pb_m_r;
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c;
  // a data change while the clock is high marks start or stop
  assign scl_rise = scl_s_r && !scl_d_r;
  assign scl_fall = !scl_s_r && scl_d_r;
  assign start_c = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
  assign stop_c = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [4:0] setup_r, setup_nxt;
  logic test_r, test_nxt;
  logic [7:0] latch_r, latch_nxt;
  logic irq_r, irq_nxt;
  logic wr_p, rd_p;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] ptr_r, ptr_nxt;

  assign sif.role = {setup_r[KSCAN_ROLE_B_BIT - 3], setup_r[KSCAN_ROLE_A_BIT - 3]}; // [RULE_04]
  assign sif.limit = i_scan_limit;
  assign sif.port_a = pa_s_r;
  assign sif.port_b = pb_s_r;

  // read mux for the byte loaded at each read
  function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [4:0] setup,
                                          input logic test, input logic [7:0] latch,
                                          input logic [7:0] live, input logic pb,
                                          input logic pa, input logic irq);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      KSCAN_ADDR_PORT_SETUP: v = {setup, pb, pa, irq}; // [RULE_05]
      KSCAN_ADDR_DISP_CHECK: v = {7'h00, test};
      KSCAN_ADDR_KEY_LATCH: v = latch;
      KSCAN_ADDR_KEY_LIVE: v = live; // [RULE_12]
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  assign rdata = reg_read(ptr_r, setup_r, test_r, latch_r, sif.pressed, pb_s_r, pa_s_r, irq_r);

  // register updates; a new debounce event beats a read clear
  always_comb begin
    setup_nxt = setup_r;
    test_nxt = test_r;
    if (wr_p) begin
      case (ptr_r)
        KSCAN_ADDR_PORT_SETUP: setup_nxt = wdata[KSCAN_PIN_MODE_HI:KSCAN_ROLE_A_BIT]; // [RULE_04]
        KSCAN_ADDR_DISP_CHECK: test_nxt = wdata[KSCAN_TEST_BIT]; // [RULE_15]
        default: setup_nxt = setup_r; // latched and live are read only [RULE_11] [RULE_14]
      endcase
    end
    latch_nxt = latch_r;
    irq_nxt = irq_r;
    if (rd_p && ptr_r == KSCAN_ADDR_KEY_LATCH) begin
      latch_nxt = 8'h00; // [RULE_08]
      irq_nxt = 1'b0; // [RULE_09]
    end
    if (sif.done) begin
      latch_nxt = latch_nxt | sif.fresh; // [RULE_07] [RULE_08]
      irq_nxt = irq_nxt | (|sif.fresh); // [RULE_18]
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      setup_r <= KSCAN_PORT_SETUP_RST;
      test_r <= KSCAN_DISP_CHECK_RST;
      latch_r <= 8'h00;
      irq_r <= 1'b0;
    end else begin
      setup_r <= setup_nxt;
      test_r <= test_nxt;
      latch_r <= latch_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // serial slave: address, pointer byte, then data with auto increment
  // ----------------------------------------------------------------
  kscan_state_e st_r, st_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic rw_r, rw_nxt, ptr_ph_r, ptr_ph_nxt, oe_b_r, oe_b_nxt;

  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    rw_nxt = rw_r;
    ptr_ph_nxt = ptr_ph_r;
    ptr_nxt = ptr_r;
    oe_b_nxt = oe_b_r;
    wr_p = 1'b0;
    rd_p = 1'b0;
    wdata = sh_r;
    if (start_c) begin
      st_nxt = KSCAN_ST_ADDR;
      bit_nxt = 4'h0;
      ptr_ph_nxt = 1'b1;
      oe_b_nxt = 1'b1;
    end else if (stop_c) begin
      st_nxt = KSCAN_ST_IDLE;
      oe_b_nxt = 1'b1;
    end else begin
      case (st_r)
        KSCAN_ST_ADDR, KSCAN_ST_WBYTE: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_s_r};
            bit_nxt = bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'h8) begin
            st_nxt = KSCAN_ST_SACK;
            oe_b_nxt = 1'b0;
            if (st_r == KSCAN_ST_ADDR) begin
              rw_nxt = sh_r[0];
              if (sh_r[7:1] != SLAVE_ADDR) begin
                st_nxt = KSCAN_ST_IDLE;
                oe_b_nxt = 1'b1;
              end
            end else if (ptr_ph_r) begin
              ptr_nxt = sh_r;
              ptr_ph_nxt = 1'b0;
            end else begin
              wr_p = 1'b1;
              ptr_nxt = ptr_r + 8'h1;
            end
          end
        end
        KSCAN_ST_SACK, KSCAN_ST_MACK: begin
          if (scl_rise && st_r == KSCAN_ST_MACK) begin
            sh_nxt[0] = sda_s_r;
          end else if (scl_fall) begin
            bit_nxt = 4'h0;
            oe_b_nxt = 1'b1;
            st_nxt = KSCAN_ST_WBYTE;
            if (st_r == KSCAN_ST_MACK && sh_r[0]) begin
              st_nxt = KSCAN_ST_IDLE;
            end else if (rw_r) begin
              // load snapshot; clear-on-read acts here only
              rd_p = 1'b1;
              sh_nxt = rdata;
              oe_b_nxt = rdata[7];
              bit_nxt = 4'h1;
              ptr_nxt = ptr_r + 8'h1;
              st_nxt = KSCAN_ST_RBYTE;
            end
          end
        end
        KSCAN_ST_RBYTE: begin
          if (scl_fall) begin
            if (bit_r == 4'h8) begin
              oe_b_nxt = 1'b1;
              st_nxt = KSCAN_ST_MACK;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              oe_b_nxt = sh_r[6];
              bit_nxt = bit_r + 4'h1;
            end
          end
        end
        default: st_nxt = KSCAN_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= KSCAN_ST_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      rw_r <= 1'b0;
      ptr_ph_r <= 1'b0;
      ptr_r <= 8'h00;
      oe_b_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      rw_r <= rw_nxt;
      ptr_ph_r <= ptr_ph_nxt;
      ptr_r <= ptr_nxt;
      oe_b_r <= oe_b_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pin and display outputs, all registered
  // ----------------------------------------------------------------
  logic alert_out_nxt, alert_oe_b_nxt;
  logic [5:0] duty_nxt;

  // open-drain modes release the pin for a high level
  always_comb begin
    alert_out_nxt = 1'b0;
    alert_oe_b_nxt = 1'b1;
    duty_nxt = test_r ? KSCAN_DUTY_TEST : i_intensity; // [RULE_17]
    if (setup_r[4]) begin
      alert_oe_b_nxt = 1'b0; // [RULE_01]
      alert_out_nxt = test_r || i_alert_seg_level; // [RULE_16]
    end else begin
      case (setup_r[4:2])
        KSCAN_PIN_GPO_LOW: alert_oe_b_nxt = 1'b0; // [RULE_02]
        KSCAN_PIN_GPO_HIGH: alert_oe_b_nxt = 1'b1; // [RULE_02]
        KSCAN_PIN_IRQ_LOW: alert_oe_b_nxt = !irq_r; // [RULE_03]
        KSCAN_PIN_IRQ_HIGH: alert_oe_b_nxt = irq_r; // [RULE_03]
        default: alert_oe_b_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sda_out <= 1'b0;
      o_sda_oe_b <= 1'b1;
      o_alert_out <= 1'b0;
      o_alert_oe_b <= 1'b1;
      o_dig_drive_n <= 4'hF;
      o_force_all_on <= 1'b0;
      o_blank <= 1'b0;
      o_duty_code <= 6'h00;
    end else begin
      o_sda_out <= 1'b0;
      o_sda_oe_b <= oe_b_r;
      o_alert_out <= alert_out_nxt;
      o_alert_oe_b <= alert_oe_b_nxt;
      o_dig_drive_n <= sif.dig_n;
      o_force_all_on <= test_r; // [RULE_16]
      o_blank <= i_shutdown && !test_r; // [RULE_16]
      o_duty_code <= duty_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_latch_read;
    rd_p && ptr_r == KSCAN_ADDR_KEY_LATCH && !sif.done;
  endsequence
  sequence s_live_read;
    rd_p && ptr_r == KSCAN_ADDR_KEY_LIVE && !sif.done;
  endsequence

  a_seg_mode_drive: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // [RULE_01]
    setup_r[4] |=> !o_alert_oe_b) else $error("segment mode not driving");
  a_gpo_level: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // [RULE_02]
    setup_r[4:2] == KSCAN_PIN_GPO_LOW |=> !o_alert_oe_b && !o_alert_out) else $error("gpo low wrong");
  a_irq_low_pin: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // [RULE_03]
    setup_r[4:2] == KSCAN_PIN_IRQ_LOW && $stable(setup_r) |=> o_alert_oe_b == !$past(irq_r))
    else $error("active-low irq pin wrong");
  a_latch_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // [RULE_09]
    s_latch_read |=> latch_r == 8'h00 && !irq_r ##1 o_alert_oe_b || setup_r[4:2] != KSCAN_PIN_IRQ_LOW)
    else $error("latched read did not clear");
  a_live_no_side: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // [RULE_13]
    s_live_read |=> $stable(latch_r) && $stable(irq_r)) else $error("live read had side effect");
  a_latch_accum: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // [RULE_08]
    sif.done && !rd_p |=> latch_r == ($past(latch_r) | $past(sif.fresh)))
    else $error("event lost");
  a_ro_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // [RULE_11]
    wr_p && ptr_r == KSCAN_ADDR_KEY_LATCH && !sif.done |=> $stable(latch_r)) else $error("ro write took");
  a_test_duty: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // [RULE_17]
    test_r [*2] |-> o_duty_code == KSCAN_DUTY_TEST && o_force_all_on) else $error("test duty wrong");
  a_irq_event: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // [RULE_18]
    sif.done && |sif.fresh |=> irq_r && latch_r != 8'h00) else $error("event raised no irq");
endmodule

// file: verilog/kscan_pkg.sv
package kscan_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] KSCAN_ADDR_PORT_SETUP = 8'h06;
  localparam logic [7:0] KSCAN_ADDR_DISP_CHECK = 8'h07;
  localparam logic [7:0] KSCAN_ADDR_KEY_LATCH = 8'h08;
  localparam logic [7:0] KSCAN_ADDR_KEY_LIVE = 8'h0C;
  // port_setup and display check fields
  localparam int KSCAN_PIN_MODE_HI = 7;
  localparam int KSCAN_PIN_MODE_LO = 5;
  localparam int KSCAN_ROLE_B_BIT = 4;
  localparam int KSCAN_ROLE_A_BIT = 3;
  localparam int KSCAN_TEST_BIT = 0;
  localparam logic [4:0] KSCAN_PORT_SETUP_RST = 5'h00;
  localparam logic KSCAN_DISP_CHECK_RST = 1'b0;
  // shared pin modes (bit 7 set means segment driver)
  localparam logic [2:0] KSCAN_PIN_GPO_LOW = 3'h0;
  localparam logic [2:0] KSCAN_PIN_GPO_HIGH = 3'h1;
  localparam logic [2:0] KSCAN_PIN_IRQ_LOW = 3'h2;
  localparam logic [2:0] KSCAN_PIN_IRQ_HIGH = 3'h3;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int KSCAN_CLK_PERIOD_PS = 5000;
  localparam int KSCAN_DIGIT_TIME_NS = 320000;
  localparam int KSCAN_DIGIT_CYC = (KSCAN_DIGIT_TIME_NS * 1000) / KSCAN_CLK_PERIOD_PS;
  // duty codes: code n gives (n+1)/64
  localparam logic [5:0] KSCAN_DUTY_TEST = 6'h1B;
  localparam logic [6:0] KSCAN_SLAVE_ADDR = 7'h38;
endpackage

// file: verilog/kscan_if.sv
`timescale 1ns/10ps
interface kscan_if;
  logic [1:0] role;
  logic [1:0] limit;
  logic port_a;
  logic port_b;
  logic [3:0] dig_n;
  logic [7:0] pressed;
  logic [7:0] fresh;
  logic done;
  modport bank (output role, output limit, output port_a, output port_b,
                input dig_n, input pressed, input fresh, input done);
  modport scanner (input role, input limit, input port_a, input port_b,
                   output dig_n, output pressed, output fresh, output done);
endinterface

// file: verilog/kscan_scanner.sv
`timescale 1ns/10ps
module kscan_scanner
  import kscan_pkg::*;
#(
  parameter int DIGIT_CYCLES = KSCAN_DIGIT_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  kscan_if.scanner sif
);
  logic [31:0] cnt_r, cnt_nxt;
  logic [1:0] dig_r, dig_nxt;
  logic pass_r, pass_nxt;
  logic [7:0] samp0_r, samp0_nxt, samp1_r, samp1_nxt, prev_r, prev_nxt;
  logic [7:0] pressed_r, pressed_nxt, fresh_r, fresh_nxt;
  logic [3:0] dig_n_r, dig_n_nxt;
  logic done_r, done_nxt;
  logic [7:0] mask;
  logic [7:0] hit;

  // ----------------------------------------------------------------
  // scan sequencing: two passes over enabled digits form one cycle
  // ----------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r + 32'h1;
    dig_nxt = dig_r;
    pass_nxt = pass_r;
    samp0_nxt = samp0_r;
    samp1_nxt = samp1_r;
    prev_nxt = prev_r;
    pressed_nxt = pressed_r;
    fresh_nxt = 8'h00;
    done_nxt = 1'b0;
    // keys only count on keyscan ports and within the scan limit
    for (int k = 0; k < 4; k++) begin
      mask[k] = sif.role[0] && (2'(k) <= sif.limit); // [RULE_19] [RULE_20]
      mask[k + 4] = sif.role[1] && (2'(k) <= sif.limit); // [RULE_06]
      hit[k] = (dig_r == 2'(k)) && !sif.port_a;
      hit[k + 4] = (dig_r == 2'(k)) && !sif.port_b;
    end
    if (cnt_r == 32'(DIGIT_CYCLES / 2)) begin
      if (pass_r) samp1_nxt = samp1_r | hit;
      else samp0_nxt = samp0_r | hit;
    end
    if (cnt_r >= 32'(DIGIT_CYCLES - 1)) begin
      cnt_nxt = 32'h0;
      if (dig_r >= sif.limit) begin
        dig_nxt = 2'h0;
        pass_nxt = !pass_r;
        if (pass_r) begin
          // pressed in both sampling periods
          pressed_nxt = samp0_r & samp1_r & mask; // [RULE_12] [RULE_18]
          fresh_nxt = samp0_r & samp1_r & mask & ~prev_r; // [RULE_10]
          prev_nxt = samp0_r & samp1_r & mask;
          samp0_nxt = 8'h00;
          samp1_nxt = 8'h00;
          done_nxt = 1'b1;
        end
      end else begin
        dig_nxt = dig_r + 2'h1;
      end
    end
    dig_n_nxt = ~(4'h1 << dig_nxt);
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= 32'h0;
      dig_r <= 2'h0;
      pass_r <= 1'b0;
      samp0_r <= 8'h00;
      samp1_r <= 8'h00;
      prev_r <= 8'h00;
      pressed_r <= 8'h00;
      fresh_r <= 8'h00;
      dig_n_r <= 4'hE;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      dig_r <= dig_nxt;
      pass_r <= pass_nxt;
      samp0_r <= samp0_nxt;
      samp1_r <= samp1_nxt;
      prev_r <= prev_nxt;
      pressed_r <= pressed_nxt;
      fresh_r <= fresh_nxt;
      dig_n_r <= dig_n_nxt;
      done_r <= done_nxt;
    end
  end

  assign sif.dig_n = dig_n_r;
  assign sif.pressed = pressed_r;
  assign sif.fresh = fresh_r;
  assign sif.done = done_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_fresh_once: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // [RULE_10]
    done_r |-> (fresh_r & $past(prev_r)) == 8'h00) else $error("held key reported twice");
  a_fresh_masked: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // [RULE_20]
    done_r && !sif.role[0] |-> sif.pressed[3:0] == 4'h0) else $error("logic port key seen");
endmodule

// file: dv/kscan_host.sv
`timescale 1ns/10ps
// --------------------------------------------------------------
// host controller on the 2-wire link, 80 ns bit time
// --------------------------------------------------------------
module kscan_host #(
  parameter logic [6:0] ADDR = 7'h38
) (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_b
);
  logic nack;

  // link clock stands high between frames
  initial begin
    o_scl = 1'b1;
    o_sda_b = 1'b1;
    nack = 1'b0;
  end

  // one bit: data set mid-low, sampled mid-high
  task automatic bitx(input logic b, output logic s);
    o_sda_b = b;
    #20 o_scl = 1'b1;
    #20 s = i_sda;
    #20 o_scl = 1'b0;
    #20;
  endtask

  // also serves as repeated start from a low clock
  task automatic start();
    o_sda_b = 1'b1;
    #20 o_scl = 1'b1;
    #20 o_sda_b = 1'b0;
    #20 o_scl = 1'b0;
    #20;
  endtask

  task automatic stop();
    o_sda_b = 1'b0;
    #20 o_scl = 1'b1;
    #20 o_sda_b = 1'b1;
    #20;
  endtask

  // msb first, then the device's acknowledge
  task automatic tx(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], s);
    end
    bitx(1'b1, s);
    if (s) begin
      nack = 1'b1;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    nack = 1'b0;
    start();
    tx({ADDR, 1'b0});
    tx(a);
    tx(d); // role bits written in 4..3
    stop();
  endtask

  // single byte read, closed by a not-acknowledge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic s;
    nack = 1'b0;
    start();
    tx({ADDR, 1'b0});
    tx(a);
    start();
    tx({ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      d[i] = s;
    end
    bitx(1'b1, s);
    stop();
  endtask
endmodule

// file: dv/kscan_port_status_regs_bench.sv
`timescale 1ns/10ps
module kscan_port_status_regs_bench
  import kscan_pkg::*;
;
  typedef struct {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic pin;
    logic force_on;
  } kscan_row_s;

  logic i_sys_clk, i_rst_b, scl, host_sda_b, sda, port_a, port_b, alert_pin, shutdown, seg_lvl;
  logic [1:0] limit;
  logic [7:0] keys;
  logic sda_out, sda_oe_b, alert_out, alert_oe_b, force_on, blank;
  logic [3:0] dig_n;
  logic [5:0] duty;
  int n_errors = 0;
  int n_checks = 0;
  // segment level kept low so segment mode is told apart from the pull-up
  kscan_row_s rows[9] = '{
    '{8'h06, 8'h00, 8'h06, 1'b0, 1'b0}, '{8'h06, 8'h20, 8'h26, 1'b1, 1'b0},
    '{8'h06, 8'h40, 8'h46, 1'b1, 1'b0}, '{8'h06, 8'h60, 8'h66, 1'b0, 1'b0},
    '{8'h06, 8'h80, 8'h86, 1'b0, 1'b0}, '{8'h06, 8'hE0, 8'hE6, 1'b0, 1'b0},
    '{8'h06, 8'h1F, 8'h1E, 1'b0, 1'b0}, '{8'h07, 8'h01, 8'h01, 1'b0, 1'b1},
    '{8'h07, 8'hFE, 8'h00, 1'b0, 1'b0}};

  // --------------------------------------------------------------
  // wires: open-drain data line and pin, key matrix on digit strobes
  // --------------------------------------------------------------
  assign sda = host_sda_b & (sda_oe_b | sda_out);
  assign alert_pin = alert_oe_b ? 1'b1 : alert_out;
  assign port_a = ~|(~dig_n & keys[3:0]);
  assign port_b = ~|(~dig_n & keys[7:4]);

  kscan_port_status_regs #(.DIGIT_CYCLES(20)) dut (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda_in(sda),
    .i_scan_port_a(port_a), .i_scan_port_b(port_b), .i_scan_limit(limit),
    .i_intensity(6'h05), .i_shutdown(shutdown), .i_alert_seg_level(seg_lvl),
    .o_sda_out(sda_out), .o_sda_oe_b(sda_oe_b), .o_alert_out(alert_out),
    .o_alert_oe_b(alert_oe_b), .o_dig_drive_n(dig_n), .o_force_all_on(force_on),
    .o_blank(blank), .o_duty_code(duty));

  kscan_host host (.i_sda(sda), .o_scl(scl), .o_sda_b(host_sda_b));

  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  // --------------------------------------------------------------
  // checking and link helpers
  // --------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk) #1;
    host.wr(a, d);
    chk("write ack", 8'h00, {7'h00, host.nack});
  endtask

  task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] d;
    @(posedge i_sys_clk) #1;
    host.rd(a, d);
    chk({n, " ack"}, 8'h00, {7'h00, host.nack});
    chk(n, e, d & m);
  endtask

  // two and a half scan cycles at four digits, so a new press is seen twice
  task automatic wait_scan();
    repeat (400) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // a full run needs some 23k cycles
  initial begin
    repeat (80000) @(posedge i_sys_clk);
    n_errors++;
    $display("watchdog expired");
    stop_test();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    i_rst_b = 1'b0;
    limit = 2'h3;
    keys = 8'h00;
    shutdown = 1'b1;
    seg_lvl = 1'b0;
    repeat (8) @(posedge i_sys_clk);
    #1 i_rst_b = 1'b1;
    repeat (4) @(posedge i_sys_clk);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rdchk("readback", rows[i].addr, rows[i].rdata, 8'hFF);
      chk("pin", {7'h00, rows[i].pin}, {7'h00, alert_pin});
      chk("force", {7'h00, rows[i].force_on}, {7'h00, force_on});
      chk("blank", {7'h00, ~rows[i].force_on}, {7'h00, blank});
      chk("duty", {2'h0, rows[i].force_on ? KSCAN_DUTY_TEST : 6'h05}, {2'h0, duty});
    end
    // test mode is off here, so shutdown alone decides blanking
    shutdown = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1 chk("awake", 8'h00, {7'h00, blank});
    shutdown = 1'b1;
    $display("table done");
    // second reset in mid-run, test mode still set beforehand
    wr(8'h07, 8'h01);
    #1 i_rst_b = 1'b0;
    repeat (8) @(posedge i_sys_clk);
    #1 i_rst_b = 1'b1;
    repeat (4) @(posedge i_sys_clk);
    chk("reset pin", 8'h00, {7'h00, alert_pin});
    rdchk("reset setup", 8'h06, 8'h06, 8'hFF);
    rdchk("reset test", 8'h07, 8'h00, 8'hFF);
    rdchk("unmapped", 8'h0D, 8'h00, 8'hFF);
    $display("reset test done");
    // port a scanning only, active-low interrupt
    wr(8'h06, 8'h48);
    keys = 8'h22;
    wait_scan();
    chk("irq low", 8'h00, {7'h00, alert_pin});
    rdchk("live a only", 8'h0C, 8'h02, 8'hFF);
    chk("irq kept", 8'h00, {7'h00, alert_pin});
    rdchk("irq flag", 8'h06, 8'h49, 8'hF9);
    rdchk("latched", 8'h08, 8'h02, 8'hFF);
    chk("irq cleared", 8'h01, {7'h00, alert_pin});
    wait_scan();
    rdchk("held once", 8'h08, 8'h00, 8'hFF);
    chk("no new irq", 8'h01, {7'h00, alert_pin});
    keys = 8'h00;
    wait_scan();
    keys = 8'h01;
    wait_scan();
    keys = 8'h08;
    wait_scan();
    wr(8'h08, 8'hFF);
    rdchk("accumulate", 8'h08, 8'h09, 8'hFF);
    wr(8'h0C, 8'h00);
    rdchk("live kept", 8'h0C, 8'h08, 8'hFF);
    $display("port a test done");
    // both ports scanning, active-high interrupt, then one digit only
    wr(8'h06, 8'h78);
    keys = 8'h90;
    wait_scan();
    chk("irq high", 8'h01, {7'h00, alert_pin});
    rdchk("live both", 8'h0C, 8'h90, 8'hFF);
    rdchk("latched both", 8'h08, 8'h90, 8'hFF);
    chk("irq high off", 8'h00, {7'h00, alert_pin});
    limit = 2'h0;
    wait_scan();
    rdchk("limited", 8'h0C, 8'h10, 8'hFF);
    wr(8'h06, 8'h80);
    chk("segment", 8'h00, {7'h00, alert_oe_b});
    seg_lvl = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1 chk("segment level", 8'h01, {7'h00, alert_pin});
    seg_lvl = 1'b0;
    wr(8'h07, 8'h01);
    chk("segment test", 8'h01, {7'h00, alert_pin});
    $display("both ports test done");
    stop_test();
  end
endmodule
